/* core/sbd_bridge.sv */
// Purpose: Decode and control for the streaming-link bridge function
// Assumes: Host and link completion logic on clk_i
// Notes:   Avalon-MM slave, one wait state per access
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module sbd_bridge
	import sbd_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [9:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire sbd_req_t    host_req_i,
	output sbd_route_t       route_o,
	input  wire sbd_done_t   link_done_i,
	output sbd_cpl_t         host_cpl_o,
	output logic             serr_msg_o,
	output logic [2:0]       lowest_subordinate_hub_o,
	output logic [2:0]       highest_subordinate_hub_o,
	output logic [1:0]       link_width_select_o
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic [31:0] pbase;
		logic [31:0] ptop;
		logic [31:0] bctl;
		logic [31:0] errcmd;
		logic [31:0] link;
		logic [31:0] cmd;
		logic [31:0] iowin;
		logic [31:0] legacy;
		logic [31:0] stat;
		sbd_route_t  route;
		sbd_cpl_t    cpl;
		logic        serr;
	} sbd_state_t;

	sbd_state_t state_q;
	sbd_state_t state_d;

	logic [7:0]  reg_idx;
	logic        idx_ok;
	logic        acc_done;
	logic        wr_done;
	logic        pf_hit;
	logic        io_hit;
	logic        is_vga;
	logic        is_mda;
	logic        isa_alias;
	logic        legacy_ill;
	logic [31:0] rd_mux;
	logic [31:0] stat_view;

	// ****************************************
	// Bus decode
	// ****************************************
	assign reg_idx  = avs_address_i[9:2];
	assign idx_ok   = avs_address_i[1:0] == 2'h0;
	assign acc_done = (avs_read_i | avs_write_i) & state_q.ack;
	assign wr_done  = avs_write_i & state_q.ack & idx_ok;

	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~state_q.ack;

	// ****************************************
	// Window and legacy decode
	// ****************************************
	sbd_win_cmp #(
		.W (12)
	) u_pf_win (
		.addr_i (host_req_i.addr[31:20]),
		.base_i (state_q.pbase[15:4]),
		.top_i  (state_q.ptop[15:4]),
		.hit_o  (pf_hit)
	);

	sbd_win_cmp #(
		.W (4)
	) u_io_win (
		.addr_i (host_req_i.addr[15:12]),
		.base_i (state_q.iowin[7:4]),
		.top_i  (state_q.iowin[15:12]),
		.hit_o  (io_hit)
	);

	sbd_legacy_dec u_legacy (
		.req_i (host_req_i),
		.vga_o (is_vga),
		.mda_o (is_mda)
	);

	assign isa_alias  = host_req_i.addr[9:8] != 2'h0;
	assign legacy_ill = ~state_q.bctl[SBD_B_VGA]
		& state_q.legacy[SBD_B_MONO];

	// ****************************************
	// Status view
	// ****************************************
	always_comb begin
		stat_view = state_q.stat & SBD_MSK_STAT;
		stat_view[SBD_B_ST_ILL] = legacy_ill;
	end

	// ****************************************
	// Read mux
	// ****************************************
	always_comb begin
		rd_mux = SBD_RST_ZERO;
		if (idx_ok) begin
			unique case (reg_idx)
				SBD_IDX_PBASE: begin
					rd_mux = state_q.pbase & SBD_MSK_WIN;
				end
				SBD_IDX_PTOP: begin
					rd_mux = state_q.ptop & SBD_MSK_WIN;
				end
				SBD_IDX_BCTL: begin
					// Bits 7,6,5,4,1,0 stay zero
					rd_mux = state_q.bctl & SBD_MSK_BCTL;
				end
				SBD_IDX_ERRCMD: begin
					rd_mux = state_q.errcmd & SBD_MSK_ERRCMD;
				end
				SBD_IDX_LINK: begin
					rd_mux = (state_q.link & SBD_MSK_LINK)
						| (SBD_RST_LINK & ~SBD_MSK_LINK);
				end
				SBD_IDX_CMD: begin
					rd_mux = state_q.cmd & SBD_MSK_CMD;
				end
				SBD_IDX_IOWIN: begin
					rd_mux = state_q.iowin & SBD_MSK_IOWIN;
				end
				SBD_IDX_LEGACY: begin
					rd_mux = state_q.legacy & SBD_MSK_LEGACY;
				end
				SBD_IDX_STAT: begin
					rd_mux = stat_view;
				end
				default: begin
					rd_mux = SBD_RST_ZERO;
				end
			endcase
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		state_d = state_q;

		// One wait state per access
		state_d.ack   = (avs_read_i | avs_write_i) & ~state_q.ack;
		state_d.rdata = acc_done ? state_q.rdata : rd_mux;

		// Register writes
		if (wr_done) begin
			unique case (reg_idx)
				SBD_IDX_PBASE: begin
					state_d.pbase = sbd_wr(state_q.pbase,
						avs_writedata_i, avs_byteenable_i,
						SBD_MSK_WIN);
				end
				SBD_IDX_PTOP: begin
					state_d.ptop = sbd_wr(state_q.ptop,
						avs_writedata_i, avs_byteenable_i,
						SBD_MSK_WIN);
				end
				SBD_IDX_BCTL: begin
					state_d.bctl = sbd_wr(state_q.bctl,
						avs_writedata_i, avs_byteenable_i,
						SBD_MSK_BCTL);
				end
				SBD_IDX_ERRCMD: begin
					state_d.errcmd = sbd_wr(state_q.errcmd,
						avs_writedata_i, avs_byteenable_i,
						SBD_MSK_ERRCMD);
				end
				SBD_IDX_LINK: begin
					state_d.link = sbd_wr(state_q.link,
						avs_writedata_i, avs_byteenable_i,
						SBD_MSK_LINK);
				end
				SBD_IDX_CMD: begin
					state_d.cmd = sbd_wr(state_q.cmd,
						avs_writedata_i, avs_byteenable_i,
						SBD_MSK_CMD);
				end
				SBD_IDX_IOWIN: begin
					state_d.iowin = sbd_wr(state_q.iowin,
						avs_writedata_i, avs_byteenable_i,
						SBD_MSK_IOWIN);
				end
				SBD_IDX_LEGACY: begin
					state_d.legacy = sbd_wr(state_q.legacy,
						avs_writedata_i, avs_byteenable_i,
						SBD_MSK_LEGACY);
				end
				SBD_IDX_STAT: begin
					// Write one to clear
					state_d.stat = state_q.stat
						& ~(avs_writedata_i & SBD_MSK_STAT);
				end
				default: begin
					state_d.stat = state_q.stat;
				end
			endcase
		end

		// Routing of host requests
		state_d.route.valid   = host_req_i.valid;
		state_d.route.to_link = 1'b0;
		if (host_req_i.valid) begin
			if (is_vga) begin
				state_d.route.to_link = state_q.bctl[SBD_B_VGA]
					& ~is_mda;
			end else if (host_req_i.is_io) begin
				state_d.route.to_link = io_hit
					& ~(state_q.bctl[SBD_B_ISA]
					& isa_alias);
			end else begin
				state_d.route.to_link = pf_hit;
			end
		end
		state_d.route.to_hub = host_req_i.valid
			& ~state_d.route.to_link;

		// Completions back to the host
		state_d.cpl.valid   = link_done_i.valid;
		state_d.cpl.dropped = 1'b0;
		state_d.cpl.rdata   = SBD_RST_ZERO;
		if (link_done_i.valid) begin
			if (link_done_i.master_abort) begin
				state_d.cpl.dropped = ~link_done_i.is_read;
				state_d.cpl.rdata   = link_done_i.is_read
					? SBD_ALL_ONES : SBD_RST_ZERO;
			end else if (link_done_i.is_read) begin
				state_d.cpl.rdata = link_done_i.rdata;
			end
		end

		// SERR message on target abort
		state_d.serr = link_done_i.valid
			& link_done_i.target_abort
			& state_q.errcmd[SBD_B_TARGET_ABORT_SYSERR_ENABLE]
			& state_q.cmd[SBD_B_SYSERR];

		// Sticky status, set wins over clear
		if (link_done_i.valid & link_done_i.master_abort) begin
			state_d.stat[SBD_B_ST_MA] = 1'b1;
		end
		if (link_done_i.valid & link_done_i.target_abort) begin
			state_d.stat[SBD_B_ST_TA] = 1'b1;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_q.ack    <= 1'b0;
			state_q.rdata  <= SBD_RST_ZERO;
			state_q.pbase  <= SBD_RST_PBASE;
			state_q.ptop   <= SBD_RST_PTOP;
			state_q.bctl   <= SBD_RST_BCTL;
			state_q.errcmd <= SBD_RST_ERRCMD;
			state_q.link   <= SBD_RST_LINK;
			state_q.cmd    <= SBD_RST_ZERO;
			state_q.iowin  <= SBD_RST_ZERO;
			state_q.legacy <= SBD_RST_ZERO;
			state_q.stat   <= SBD_RST_ZERO;
			state_q.route  <= '0;
			state_q.cpl    <= '0;
			state_q.serr   <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign avs_readdata_o = state_q.rdata;
	assign route_o        = state_q.route;
	assign host_cpl_o     = state_q.cpl;
	assign serr_msg_o     = state_q.serr;

	assign lowest_subordinate_hub_o  = state_q.link[31:29];
	assign highest_subordinate_hub_o = state_q.link[27:25];
	assign link_width_select_o       = state_q.link[15:14];

endmodule // sbd_bridge

/* core/sbd_pkg.sv */
// Purpose: Shared constants and types of the bridge decode block
// Assumes: Avalon byte address is four times the register index
// Notes:   Widths fixed at the documented values
package sbd_pkg;

	// ****************************************
	// Register indices
	// ****************************************
	localparam logic [7:0] SBD_IDX_PBASE  = 8'h24;
	localparam logic [7:0] SBD_IDX_PTOP   = 8'h26;
	localparam logic [7:0] SBD_IDX_BCTL   = 8'h3E;
	localparam logic [7:0] SBD_IDX_ERRCMD = 8'h40;
	localparam logic [7:0] SBD_IDX_LINK   = 8'h50;
	localparam logic [7:0] SBD_IDX_CMD    = 8'h04;
	localparam logic [7:0] SBD_IDX_IOWIN  = 8'h1C;
	localparam logic [7:0] SBD_IDX_LEGACY = 8'h60;
	localparam logic [7:0] SBD_IDX_STAT   = 8'h64;

	// ****************************************
	// Reset values and writable masks
	// ****************************************
	localparam logic [31:0] SBD_RST_PBASE  = 32'h0000FFF0;
	localparam logic [31:0] SBD_RST_PTOP   = 32'h00000000;
	localparam logic [31:0] SBD_RST_BCTL   = 32'h00000000;
	localparam logic [31:0] SBD_RST_ERRCMD = 32'h00000000;
	localparam logic [31:0] SBD_RST_LINK   = 32'h0E042802;
	localparam logic [31:0] SBD_RST_ZERO   = 32'h00000000;
	localparam logic [31:0] SBD_MSK_WIN    = 32'h0000FFF0;
	localparam logic [31:0] SBD_MSK_BCTL   = 32'h0000000C;
	localparam logic [31:0] SBD_MSK_ERRCMD = 32'h00000001;
	localparam logic [31:0] SBD_MSK_LINK   = 32'hEE00C000;
	localparam logic [31:0] SBD_MSK_CMD    = 32'h00000100;
	localparam logic [31:0] SBD_MSK_IOWIN  = 32'h0000F0F0;
	localparam logic [31:0] SBD_MSK_LEGACY = 32'h00000001;
	localparam logic [31:0] SBD_MSK_STAT   = 32'h00000003;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int SBD_B_VGA     = 3;
	localparam int SBD_B_ISA     = 2;
	localparam int SBD_B_TARGET_ABORT_SYSERR_ENABLE   = 0;
	localparam int SBD_B_SYSERR  = 8;
	localparam int SBD_B_MONO    = 0;
	localparam int SBD_B_ST_MA   = 0;
	localparam int SBD_B_ST_TA   = 1;
	localparam int SBD_B_ST_ILL  = 2;
	localparam logic [31:0] SBD_ALL_ONES = 32'hFFFFFFFF;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic        valid;
		logic        is_io;
		logic [31:0] addr;
	} sbd_req_t;

	typedef struct packed {
		logic valid;
		logic to_link;
		logic to_hub;
	} sbd_route_t;

	typedef struct packed {
		logic        valid;
		logic        is_read;
		logic        master_abort;
		logic        target_abort;
		logic [31:0] rdata;
	} sbd_done_t;

	typedef struct packed {
		logic        valid;
		logic        dropped;
		logic [31:0] rdata;
	} sbd_cpl_t;

	// Byte-lane write into the writable bits only
	function automatic logic [31:0] sbd_wr(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be,
		input logic [31:0] msk);
		logic [31:0] lane;
		lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~(lane & msk)) | (wd & lane & msk);
	endfunction

endpackage

/* core/sbd_win_cmp.sv */
// Purpose: Inclusive window compare on upper address bits
// Assumes: Low bits taken as zero at base, ones at top
// Notes:   Inverted window reads as empty
`timescale 1ns/100ps
module sbd_win_cmp #(
	parameter int W = 12
) (
	input  wire logic [W-1:0] addr_i,
	input  wire logic [W-1:0] base_i,
	input  wire logic [W-1:0] top_i,
	output logic              hit_o
);

	// ****************************************
	// Compare
	// ****************************************
	always_comb begin
		hit_o = (addr_i >= base_i) && (addr_i <= top_i)
			&& (base_i <= top_i);
	end

endmodule // sbd_win_cmp

/* core/sbd_legacy_dec.sv */
// Purpose: Classify VGA and MDA legacy references
// Assumes: Standard legacy memory and I/O ranges
// Notes:   MDA ranges are a subset of the VGA ranges, except I/O port 3BF
`timescale 1ns/100ps
module sbd_legacy_dec
	import sbd_pkg::*;
(
	input  wire sbd_req_t req_i,
	output logic          vga_o,
	output logic          mda_o
);

	// ****************************************
	// Range decode
	// ****************************************
	always_comb begin
		vga_o = 1'b0;
		mda_o = 1'b0;
		if (req_i.is_io) begin
			if (req_i.addr[31:4] == 28'h000003B) begin
				vga_o = req_i.addr[3:0] <= 4'hB;
				mda_o = (req_i.addr[3:0] == 4'h4)
					|| (req_i.addr[3:0] == 4'h5)
					|| (req_i.addr[3:0] == 4'h8)
					|| (req_i.addr[3:0] == 4'h9)
					|| (req_i.addr[3:0] == 4'hA)
					|| (req_i.addr[3:0] == 4'hF);
			end
			if (req_i.addr[31:5] == 27'h000001E) begin
				vga_o = 1'b1;
			end
		end else begin
			vga_o = req_i.addr[31:17] == 15'h0005;
			mda_o = req_i.addr[31:15] == 17'h00016;
		end
	end

endmodule // sbd_legacy_dec

/* tb/sbd_bridge_monitor.sv */
// Purpose: Port checks for the bridge decode block
// Assumes: One clock, synchronous reset
// Notes:   Bound into every bridge instance
`timescale 1ns/100ps
module sbd_bridge_monitor
	import sbd_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic [9:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0]  avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire sbd_req_t    host_req_i,
	input wire sbd_route_t  route_o,
	input wire sbd_done_t   link_done_i,
	input wire sbd_cpl_t    host_cpl_o,
	input wire logic        serr_msg_o,
	input wire logic [2:0]  lowest_subordinate_hub_o,
	input wire logic [2:0]  highest_subordinate_hub_o,
	input wire logic [1:0]  link_width_select_o
);
	logic link_wr;
	assign link_wr = avs_write_i && !avs_waitrequest_o
		&& avs_address_i == 10'h140;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence s_bus_wait;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_done(logic ma, logic rd);
		link_done_i.valid && !link_done_i.target_abort
		&& link_done_i.master_abort == ma && link_done_i.is_read == rd;
	endsequence
	property p_one_wait;
		s_bus_wait |=> !avs_waitrequest_o;
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("access not answered after one wait");
	property p_route_lat;
		host_req_i.valid |=> route_o.valid
			&& (route_o.to_link != route_o.to_hub);
	endproperty
	a_route_lat: assert property (p_route_lat)
		else $error("route missing or not exclusive");
	property p_route_quiet;
		!host_req_i.valid |=> !route_o.valid;
	endproperty
	a_route_quiet: assert property (p_route_quiet)
		else $error("route without request");
	property p_ma_read;
		s_done(1'b1, 1'b1) |=> host_cpl_o.valid
			&& host_cpl_o.rdata == SBD_ALL_ONES;
	endproperty
	a_ma_read: assert property (p_ma_read)
		else $error("aborted read not all ones");
	property p_ma_write;
		s_done(1'b1, 1'b0) |=> host_cpl_o.valid && host_cpl_o.dropped;
	endproperty
	a_ma_write: assert property (p_ma_write)
		else $error("aborted write not dropped");
	property p_rd_pass;
		s_done(1'b0, 1'b1) |=> host_cpl_o.valid
			&& host_cpl_o.rdata == $past(link_done_i.rdata);
	endproperty
	a_rd_pass: assert property (p_rd_pass)
		else $error("read data not passed");
	property p_no_serr;
		!(link_done_i.valid && link_done_i.target_abort) |=> !serr_msg_o;
	endproperty
	a_no_serr: assert property (p_no_serr)
		else $error("message without target abort");
	property p_hub_hold;
		!$stable({lowest_subordinate_hub_o, highest_subordinate_hub_o,
			link_width_select_o}) |-> $past(link_wr, 1) || $past(link_wr, 2);
	endproperty
	a_hub_hold: assert property (p_hub_hold)
		else $error("link fields changed without write");
endmodule // sbd_bridge_monitor

bind sbd_bridge sbd_bridge_monitor i_sbd_bridge_monitor (.clk_i, .reset_i,
	.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
	.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .host_req_i,
	.route_o, .link_done_i, .host_cpl_o, .serr_msg_o,
	.lowest_subordinate_hub_o, .highest_subordinate_hub_o,
	.link_width_select_o);

/* tb/sbd_link_model.sv */
// Purpose: Far-side link device ending bridge transfers
// Assumes: Completion one clock after go_i
// Notes:   Idle read data toggles every cycle
`timescale 1ns/100ps
module sbd_link_model
	import sbd_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        go_i,
	input  wire logic [2:0]  kind_i,
	input  wire logic [31:0] data_i,
	output sbd_done_t        done_o
);
	always_ff @(posedge clk_i) begin
		done_o.valid        <= go_i;
		done_o.is_read      <= kind_i[0];
		done_o.master_abort <= kind_i[1];
		done_o.target_abort <= kind_i[2];
		done_o.rdata        <= go_i ? data_i : ~done_o.rdata;
	end
endmodule // sbd_link_model

/* tb/sbd_bridge_tb.sv */
// Purpose: Register and routing tests of the bridge block
// Assumes: One wait state bus, one-cycle pulses
// Notes:   Ends in print_verdict
`timescale 1ns/100ps
module sbd_bridge_tb;
	import sbd_pkg::*;
	logic        clk_i = 1'b0;
	logic        reset_i;
	logic [9:0]  avs_address_i;
	logic        avs_read_i, avs_write_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, ldata, q;
	logic [3:0]  avs_byteenable_i;
	logic        avs_waitrequest_o, serr_msg_o, go;
	sbd_req_t    host_req_i;
	sbd_route_t  route_o;
	sbd_done_t   link_done_i;
	sbd_cpl_t    host_cpl_o;
	logic [2:0]  hub_lo, hub_hi, kind;
	logic [1:0]  width;
	int          mismatches = 0;
	int          n_tests = 0;

	always #20 clk_i = ~clk_i;

	sbd_bridge i_sbd_bridge (.clk_i, .reset_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
		.avs_waitrequest_o, .host_req_i, .route_o, .link_done_i, .host_cpl_o,
		.serr_msg_o, .lowest_subordinate_hub_o(hub_lo),
		.highest_subordinate_hub_o(hub_hi), .link_width_select_o(width));
	sbd_link_model i_sbd_link_model (.clk_i, .go_i(go), .kind_i(kind),
		.data_i(ldata), .done_o(link_done_i));

	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic acc(input logic w, input logic [9:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		if (avs_waitrequest_o !== 1'b0) begin
			mismatches++;
			print_verdict();
		end
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rc(input logic [9:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic rt(input logic io, input logic [31:0] a, input logic e);
		host_req_i <= '{1'b1, io, a};
		@(posedge clk_i);
		host_req_i.valid <= 1'b0;
		@(negedge clk_i);
		chk(32'(route_o), {29'h0, 1'b1, e, !e});
		@(posedge clk_i);
	endtask
	task automatic hub(input logic [7:0] e);
		@(negedge clk_i);
		chk({24'h0, hub_lo, hub_hi, width}, {24'h0, e});
		@(posedge clk_i);
	endtask
	task automatic cp(input logic [2:0] k, input logic [31:0] d,
		input logic [31:0] e, input logic [2:0] f);
		go <= 1'b1;
		kind <= k;
		ldata <= d;
		@(posedge clk_i);
		go <= 1'b0;
		@(posedge clk_i);
		@(negedge clk_i);
		chk(host_cpl_o.rdata, e);
		chk({host_cpl_o.valid, host_cpl_o.dropped, serr_msg_o}, f);
		@(posedge clk_i);
	endtask

	initial begin
		reset_i = 1'b1;
		{avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
		avs_byteenable_i = 4'hF;
		host_req_i = '0;
		{go, kind, ldata} = '0;
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		rc(10'h090, 32'h0000FFF0);
		rc(10'h098, 32'h00000000);
		rc(10'h0F8, 32'h00000000);
		rc(10'h100, 32'h00000000);
		rc(10'h140, 32'h0E042802);
		hub(8'h1C);
		rt(1'b0, 32'h10000000, 1'b0);
		wr(10'h090, 32'hFFFF123F);
		rc(10'h090, 32'h00001230);
		wr(10'h090, 32'h00001000);
		wr(10'h098, 32'h00001FFF);
		rc(10'h098, 32'h00001FF0);
		rt(1'b0, 32'h0FFFFFFF, 1'b0);
		rt(1'b0, 32'h10000000, 1'b1);
		rt(1'b0, 32'h15555555, 1'b1);
		rt(1'b0, 32'h1FFFFFFF, 1'b1);
		rt(1'b0, 32'h20000000, 1'b0);
		wr(10'h090, 32'h00002000);
		rt(1'b0, 32'h1FF00000, 1'b0);
		wr(10'h0F8, 32'h000000FF);
		rc(10'h0F8, 32'h0000000C);
		rt(1'b0, 32'h000A0000, 1'b1);
		rt(1'b0, 32'h000B0000, 1'b0);
		wr(10'h070, 32'h00001010);
		rt(1'b1, 32'h00001300, 1'b0);
		rt(1'b1, 32'h00001100, 1'b0);
		rt(1'b1, 32'h000010FF, 1'b1);
		wr(10'h0F8, 32'h00000000);
		rt(1'b1, 32'h00001300, 1'b1);
		rt(1'b1, 32'h00002100, 1'b0);
		rt(1'b0, 32'h000A0000, 1'b0);
		wr(10'h3FC, 32'hFFFFFFFF);
		rc(10'h3FC, 32'h00000000);
		wr(10'h140, 32'hFFFFFFFF);
		rc(10'h140, 32'hEE04E802);
		hub(8'hFF);
		wr(10'h140, 32'h40000000);
		hub(8'h40);
		wr(10'h100, 32'h000000FF);
		rc(10'h100, 32'h00000001);
		wr(10'h010, 32'h00000100);
		cp(3'b011, 32'h12345678, 32'hFFFFFFFF, 3'b100);
		cp(3'b010, 32'h12345678, 32'h00000000, 3'b110);
		cp(3'b001, 32'h5A5A0F0F, 32'h5A5A0F0F, 3'b100);
		cp(3'b100, 32'h0, 32'h0, 3'b101);
		wr(10'h010, 32'h00000000);
		cp(3'b100, 32'h0, 32'h0, 3'b100);
		wr(10'h010, 32'h00000100);
		wr(10'h100, 32'h00000000);
		cp(3'b100, 32'h0, 32'h0, 3'b100);
		rc(10'h190, 32'h00000003);
		wr(10'h190, 32'h00000003);
		rc(10'h190, 32'h00000000);
		wr(10'h180, 32'h00000001);
		rc(10'h190, 32'h00000004);
		print_verdict();
	end
endmodule // sbd_bridge_tb
